/* core/scb_control0_bank.sv */
// Purpose: control-0 registers of four type-B switched-cap blocks and their phasing logic
// Assumes: phase clocks and comparator results are asynchronous pins, sampled here
// Notes: phase edges are seen a few system clocks late; the analog switches tolerate that
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module scb_control0_bank #(
  parameter int HALF_COUNT_W = 8
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [scb_pkg::ADDR_W-1:0] ADDR,
  input wire logic [scb_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [scb_pkg::DATA_W-1:0] RDATA,
  input wire logic FIRST_PHASE_CLOCK,
  input wire logic SECOND_PHASE_CLOCK,
  input wire logic SAMPLE_HOLD_DISABLE,
  input wire logic [scb_pkg::NUM_BLOCKS-1:0] COLUMN_BUS_DRIVE,
  input wire logic [scb_pkg::NUM_BLOCKS-1:0] COMPARATOR_IN,
  output logic [scb_pkg::NUM_BLOCKS-1:0] COMPARATOR_COLUMN_BUS,
  output scb_pkg::scb_phasing_t PHASING [scb_pkg::NUM_BLOCKS]
);
  import scb_pkg::*;

  // a counter narrower than two bits cannot split a second phase into halves,
  // so such a width is refused while the design is built
  generate
    if (HALF_COUNT_W < 2) begin : g_bad_width
      $error("HALF_COUNT_W too small");
    end
  endgenerate

  scb_ctrl0_t ctrl_sw [NUM_BLOCKS];
  scb_ctrl0_t ctrl_act [NUM_BLOCKS];
  logic [2:0] p1_sync;
  logic [2:0] p2_sync;
  logic [2:0] shd_sync;
  logic p1;
  logic p2;
  logic p1_q;
  logic p2_q;
  logic shd;
  logic [NUM_BLOCKS-1:0] cmp_s1;
  logic [NUM_BLOCKS-1:0] cmp_s2;
  logic [NUM_BLOCKS-1:0] cmp_s3;
  logic [NUM_BLOCKS-1:0] cmp_stable;
  logic [HALF_COUNT_W-1:0] p2_len;
  logic [HALF_COUNT_W-1:0] p2_cnt;
  logic [NUM_BLOCKS-1:0] hit;
  logic [NUM_BLOCKS-1:0] cmp_capt;
  logic [DATA_W-1:0] next_rdata;
  logic p1_rise;
  logic p1_fall;
  logic p2_rise;
  logic p2_fall;
  logic boundary;

  // address decode, one hit line per block
  always_comb begin
    hit[0] = (ADDR == ADDR_BLOCK11);
    hit[1] = (ADDR == ADDR_BLOCK13);
    hit[2] = (ADDR == ADDR_BLOCK20);
    hit[3] = (ADDR == ADDR_BLOCK22);
  end

  // phase pins pass three flops; a change counts once the last two agree
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      p1_sync <= 3'h0;
      p2_sync <= 3'h0;
      shd_sync <= 3'h0;
      p1 <= 1'b0;
      p2 <= 1'b0;
      shd <= 1'b0;
    end else if (CLK_EN) begin
      p1_sync <= {p1_sync[1:0], FIRST_PHASE_CLOCK};
      p2_sync <= {p2_sync[1:0], SECOND_PHASE_CLOCK};
      shd_sync <= {shd_sync[1:0], SAMPLE_HOLD_DISABLE};
      if (p1_sync[1] == p1_sync[2]) p1 <= p1_sync[2];
      if (p2_sync[1] == p2_sync[2]) p2 <= p2_sync[2];
      if (shd_sync[1] == shd_sync[2]) shd <= shd_sync[2];
    end
  end

  // delayed copies for edge detection on the filtered phases
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
    end else if (CLK_EN) begin
      p1_q <= p1;
      p2_q <= p2;
    end
  end

  assign p1_rise = p1 & ~p1_q;
  assign p1_fall = ~p1 & p1_q;
  assign p2_rise = p2 & ~p2_q;
  assign p2_fall = ~p2 & p2_q;
  // any phase edge is a boundary; settings never change mid-phase
  assign boundary = p1_rise | p1_fall | p2_rise | p2_fall;

  // comparator pins, same three-flop treatment per block
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_s1 <= '0;
      cmp_s2 <= '0;
      cmp_s3 <= '0;
      cmp_stable <= '0;
    end else if (CLK_EN) begin
      cmp_s1 <= COMPARATOR_IN;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      cmp_stable <= (cmp_s2 & cmp_s3) | (cmp_stable & (cmp_s2 | cmp_s3));
    end
  end

  // the length of the last second phase sets where its second half starts
  // the count is cleared while the phase is low, not at its rising edge:
  // clearing on the edge would leave the old, large count visible for one
  // cycle and connect the bus for a moment at the start of the phase
  // limitation: the half point lags one phase, so a phase that shrinks connects late, and one
  // under half the last length never connects; the first phase after reset connects throughout
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      p2_cnt <= '0;
      p2_len <= '0;
    end else if (CLK_EN) begin
      if (!p2) begin
        p2_cnt <= '0;
      end else if (p2_cnt != '1) begin
        p2_cnt <= p2_cnt + 1'b1; // saturates on very long phases
      end
      if (p2_fall) p2_len <= p2_cnt;
    end
  end

  // registered read data; the software and internal copies live in the per-block generate
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= UNMAPPED_READ;
    end else if (CLK_EN) begin
      RDATA <= next_rdata;
    end
  end

  // read mux; any cycle without a mapped read returns the idle value
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (RD) begin
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        if (hit[i]) next_rdata = ctrl_sw[i];
      end
    end
  end

  // an unmapped read answers with the idle value
  a_read_unmapped: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (CLK_EN && RD && !(|hit)) |=> RDATA == UNMAPPED_READ)
    else $error("unmapped read returned data");

  // read data stand for one cycle only
  a_read_idle: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (CLK_EN && !RD) |=> RDATA == UNMAPPED_READ)
    else $error("read data held past one cycle");

  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++) begin : blk
      logic int1;
      logic int2;
      logic second_half;
      logic capt_ev;
      logic pres_ev;

      // register write; zero after reset
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          ctrl_sw[g] <= CTRL0_RESET;
        end else if (CLK_EN && WR && hit[g]) begin
          ctrl_sw[g] <= WDATA;
        end
      end

      // active copy only moves at a phase boundary so one phase sees one setting
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          ctrl_act[g] <= CTRL0_RESET;
        end else if (CLK_EN && boundary) begin
          ctrl_act[g] <= ctrl_sw[g];
        end
      end

      // internal phases follow the swap bit
      assign int1 = ctrl_act[g].phase_swap_bit ? p2 : p1;
      assign int2 = ctrl_act[g].phase_swap_bit ? p1 : p2;
      assign second_half = (p2_cnt >= (p2_len >> 1));

      // capture and present edges depend on the swap bit
      assign capt_ev = ctrl_act[g].phase_swap_bit ? p1_fall : p2_fall;
      assign pres_ev = ctrl_act[g].phase_swap_bit ? p2_rise : p1_rise;

      // two-step latch: bus holds between presentation events
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          cmp_capt[g] <= 1'b0;
          COMPARATOR_COLUMN_BUS[g] <= 1'b0;
        end else if (CLK_EN) begin
          if (capt_ev) cmp_capt[g] <= cmp_stable[g];
          if (pres_ev) COMPARATOR_COLUMN_BUS[g] <= cmp_capt[g];
        end
      end

      // registered phasing outputs
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          PHASING[g] <= '0;
        end else if (CLK_EN) begin
          PHASING[g].feedback_units <= ctrl_act[g].feedback_size_bit ?
            FEEDBACK_UNITS_LARGE : FEEDBACK_UNITS_SMALL;
          PHASING[g].a_branch_units <= ctrl_act[g].a_branch_size_field;
          PHASING[g].int_phase1 <= int1;
          PHASING[g].int_phase2 <= int2;
          PHASING[g].sample_input <= ctrl_act[g].input_polarity_bit ? int2 : int1;
          PHASING[g].sample_reference <= ctrl_act[g].input_polarity_bit ? int1 : int2;
          // early part of a plain second phase is left floating so glitches never reach the bus
          PHASING[g].out_bus_connect <= COLUMN_BUS_DRIVE[g] && int2 &&
            (second_half || ctrl_act[g].phase_swap_bit || shd);
        end
      end

      // output never connects outside the internal second phase
      a_bus_phase2: assert property (@(posedge CLOCK) disable iff (!RSTN)
        PHASING[g].out_bus_connect |-> $past(int2))
        else $error("bus connected outside phase two");

      // in the first half of a plain second phase the bus is left floating
      a_first_float: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && !second_half && !ctrl_act[g].phase_swap_bit && !shd)
        |=> !PHASING[g].out_bus_connect)
        else $error("bus connected in first half");

      // an enabled output drives in the second half of its second phase
      a_late_drive: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && COLUMN_BUS_DRIVE[g] && int2 && second_half)
        |=> PHASING[g].out_bus_connect)
        else $error("bus not connected in second half");

      // a block that is not enabled onto the bus never connects
      a_drive_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && !COLUMN_BUS_DRIVE[g]) |=> !PHASING[g].out_bus_connect)
        else $error("disabled output connected");

      // a swapped block drives for the whole of its second phase
      a_swap_full: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && COLUMN_BUS_DRIVE[g] && int2 && ctrl_act[g].phase_swap_bit)
        |=> PHASING[g].out_bus_connect)
        else $error("swapped block not driving whole phase two");

      // global hold disable lets every enabled output drive the whole phase
      a_shd_full: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && COLUMN_BUS_DRIVE[g] && int2 && shd) |=> PHASING[g].out_bus_connect)
        else $error("hold disable ignored");

      // internal first phase follows the swap bit
      a_int_first: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $past(CLK_EN) |-> PHASING[g].int_phase1 ==
        ($past(ctrl_act[g].phase_swap_bit) ? $past(p2) : $past(p1)))
        else $error("internal first phase wrong");

      // internal second phase is always the other external phase
      a_int_second: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $past(CLK_EN) |-> PHASING[g].int_phase2 ==
        ($past(ctrl_act[g].phase_swap_bit) ? $past(p1) : $past(p2)))
        else $error("internal second phase wrong");

      // comparator bus holds between presentation events
      a_cmp_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !$past(pres_ev) |-> $stable(COMPARATOR_COLUMN_BUS[g]))
        else $error("comparator bus moved without presentation");

      // the captured value only moves on a capture event
      a_capt_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !(CLK_EN && capt_ev) |=> $stable(cmp_capt[g]))
        else $error("comparator capture moved without event");

      // capture takes the filtered comparator level
      a_capt_event: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && capt_ev) |=> cmp_capt[g] == $past(cmp_stable[g]))
        else $error("comparator not captured");

      // presentation moves the captured value onto the bus
      a_cmp_present: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && pres_ev) |=> COMPARATOR_COLUMN_BUS[g] == $past(cmp_capt[g]))
        else $error("comparator bus not presented");

      // feedback capacitor size follows its bit
      a_fb_size: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CLK_EN ##1 1'b1 |-> PHASING[g].feedback_units ==
        ($past(ctrl_act[g].feedback_size_bit) ? FEEDBACK_UNITS_LARGE : FEEDBACK_UNITS_SMALL))
        else $error("feedback size wrong");

      // input sampling phase follows the polarity bit
      a_polarity: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CLK_EN ##1 1'b1 |-> PHASING[g].sample_input ==
        ($past(ctrl_act[g].input_polarity_bit) ? $past(int2) : $past(int1)))
        else $error("input sampling phase wrong");

      // reference is sampled on the other internal phase
      a_ref_phase: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $past(CLK_EN) |-> PHASING[g].sample_reference ==
        ($past(ctrl_act[g].input_polarity_bit) ? $past(int1) : $past(int2)))
        else $error("reference sampling phase wrong");

      // branch size is a plain count of units
      a_a_branch_size_field_units: assert property (@(posedge CLOCK) disable iff (!RSTN)
        CLK_EN ##1 1'b1 |-> PHASING[g].a_branch_units ==
        $past(ctrl_act[g].a_branch_size_field))
        else $error("a branch size wrong");

      // settings only move at a phase boundary
      a_act_boundary: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !$past(boundary) |-> $stable(ctrl_act[g]))
        else $error("settings changed mid phase");

      // at a boundary the active copy takes the software value
      a_act_copy: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && boundary) |=> ctrl_act[g] == $past(ctrl_sw[g]))
        else $error("settings not applied at boundary");

      // a mapped write is stored
      a_write_store: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && WR && hit[g]) |=> ctrl_sw[g] == $past(WDATA))
        else $error("register write lost");

      // with the clock enable low the register is frozen
      a_write_frozen: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !CLK_EN |=> $stable(ctrl_sw[g]))
        else $error("register moved while frozen");

      // a read right behind a write returns the new value
      a_write_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (CLK_EN && WR && hit[g]) ##1 (CLK_EN && RD && hit[g] && !WR)
        |=> RDATA == $past(WDATA, 2))
        else $error("register readback wrong");
    end
  endgenerate
endmodule

/* common/scb_pkg.sv */
// Purpose: constants and carrier types for the type-B switched-cap control-0 bank
// Assumes: 100 MHz system clock; phase clocks arrive as pins from the column clocking
// Notes: four blocks, one control-0 register each
// Overview of operation
// - feedback capacitor is 16 units when bit 7 is 0, 32 when 1.
// - phase swap 0 uses external first phase, 1 uses external second phase.
// - with swap 0 and hold disable off, enabled output drives output bus only in second half of second phase.
// - phase swap 1 lets the output drive for the whole second phase.
// - global sample-hold disable lets every enabled output drive all second phase.
// - comparator captured on one falling phase, presented on other rising phase.
// - swap 0 captures falling second, presents rising first; swap 1 reversed.
// - polarity 0 samples input on phase one, reference on two; 1 swaps.
// - bits 4..0 are a binary count of A-branch unit capacitors, 0 to 31.
// - registers at 84h, 8Ch, 90h, 98h, read-write, zero after reset.
package scb_pkg;
  localparam int NUM_BLOCKS = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK11 = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK13 = 8'h8C;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK20 = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK22 = 8'h98;
  localparam logic [DATA_W-1:0] CTRL0_RESET = 8'h00;
  localparam int FEEDBACK_SIZE_POS = 7;
  localparam int PHASE_SWAP_POS = 6;
  localparam int INPUT_POLARITY_POS = 5;
  localparam int A_SIZE_MSB = 4;
  localparam logic [5:0] FEEDBACK_UNITS_SMALL = 6'h10;
  localparam logic [5:0] FEEDBACK_UNITS_LARGE = 6'h20;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic feedback_size_bit;
    logic phase_swap_bit;
    logic input_polarity_bit;
    logic [4:0] a_branch_size_field;
  } scb_ctrl0_t;

  typedef struct packed {
    logic [5:0] feedback_units;
    logic [4:0] a_branch_units;
    logic int_phase1;
    logic int_phase2;
    logic sample_input;
    logic sample_reference;
    logic out_bus_connect;
  } scb_phasing_t;
endpackage

/* bench/scb_control0_bank_tb.sv */
// Purpose: self-checking bench for the control-0 bank and its phasing logic
// Assumes: phase pins held 40 clocks with 11-clock gaps, well above the pin filters
// Notes: each new setting gets one warm-up cycle, since the half-phase needs a history
`timescale 1ns/100ps
module scb_control0_bank_tb;
  import scb_pkg::*;
  logic clock, rstn, clk_en, wr, rd, first_ph, second_ph, shd, swap, cap, pres;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] drv, comp_in, comp_bus;
  logic [4:0] old_a;
  scb_phasing_t phasing [NUM_BLOCKS];
  logic [7:0] cfg [4];
  logic [7:0] blk_addr [4] = '{ADDR_BLOCK11, ADDR_BLOCK13, ADDR_BLOCK20, ADDR_BLOCK22};
  int miscompares = 0;
  int checked = 0;

  scb_control0_bank #(.HALF_COUNT_W(8)) scb_control0_bank_i (
    .CLOCK(clock), .RSTN(rstn), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FIRST_PHASE_CLOCK(first_ph), .SECOND_PHASE_CLOCK(second_ph),
    .SAMPLE_HOLD_DISABLE(shd), .COLUMN_BUS_DRIVE(drv), .COMPARATOR_IN(comp_in),
    .COMPARATOR_COLUMN_BUS(comp_bus), .PHASING(phasing));

  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task finish_test;
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand for one cycle only, so the cycle after must be back to zero
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clock);
    #1;
    check(rdata, 8'h00);
  endtask

  // i2 says whether the current external phase is the internal second phase
  task check_pts(input logic i2, input logic late);
    scb_phasing_t p;
    logic [1:0] e;
    #1;
    e = {~i2, i2};
    for (int b = 0; b < 4; b++) begin
      p = phasing[b];
      check(8'(p.feedback_units), cfg[b][7] ? 8'h20 : 8'h10);
      check(8'(p.a_branch_units), 8'(cfg[b][4:0]));
      check(8'({p.int_phase1, p.int_phase2}), 8'(e));
      check(8'({p.sample_input, p.sample_reference}), 8'(cfg[b][5] ? {e[0], e[1]} : e));
      check(8'(p.out_bus_connect), 8'(drv[b] & i2 & (late | swap | shd)));
    end
    check(8'(comp_bus), 8'({4{pres}}));
  endtask

  // one first phase then one second phase; the comparator pin flips well after capture
  task run_cycle(input logic chk, input logic cin);
    logic is2;
    for (int ph = 0; ph < 2; ph++) begin
      is2 = ph[0] ^ swap;
      @(posedge clock);
      first_ph <= (ph == 0);
      second_ph <= (ph == 1);
      if (is2) begin
        comp_in <= {4{cin}};
      end else begin
        pres = cap;
      end
      repeat (12) @(posedge clock);
      if (chk) check_pts(is2, 1'b0);
      repeat (24) @(posedge clock);
      if (chk) check_pts(is2, 1'b1);
      repeat (4) @(posedge clock);
      first_ph <= 1'b0;
      second_ph <= 1'b0;
      if (is2) cap = cin;
      repeat (8) @(posedge clock);
      if (is2) comp_in <= ~{4{cin}};
      repeat (2) @(posedge clock);
    end
  endtask

  // guard against a hang: counts as a mismatch
  initial begin
    #900000;
    miscompares++;
    finish_test;
  end

  // main sequence: register access, then every swap and sample-hold mode
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    {wr, rd, first_ph, second_ph, shd, swap, cap, pres} = '0;
    {addr, wdata, drv, comp_in, old_a} = '0;
    cfg[0] = 8'h00;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (int b = 0; b < 4; b++) rd_chk(blk_addr[b], 8'h00);
    for (int b = 0; b < 4; b++) wr_reg(blk_addr[b], 8'(8'hA5 + b * 8'h11));
    for (int b = 0; b < 4; b++) rd_chk(blk_addr[b], 8'(8'hA5 + b * 8'h11));
    wr_reg(8'h85, 8'hFF);
    rd_chk(8'h85, 8'h00);
    rd_chk(blk_addr[0], 8'hA5);
    // a write with the clock enable low is ignored
    @(posedge clock);
    clk_en <= 1'b0;
    wr_reg(blk_addr[1], 8'h3C);
    clk_en <= 1'b1;
    rd_chk(blk_addr[1], 8'hB6);
    // write then read with no gap
    @(posedge clock);
    wr <= 1'b1;
    addr <= blk_addr[2];
    wdata <= 8'h5A;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      swap = m[0];
      shd <= m[1];
      drv <= m[1] ? 4'hA : 4'h5;
      old_a = cfg[0][4:0];
      for (int b = 0; b < 4; b++) begin
        cfg[b] = {b[0], swap, b[1], (b == 3) ? 5'h1F : 5'(b * 9 + m)};
        wr_reg(blk_addr[b], cfg[b]);
      end
      repeat (8) @(posedge clock);
      #1;
      check(8'(phasing[0].a_branch_units), 8'(old_a));
      run_cycle(1'b0, 1'b1);
      run_cycle(1'b1, 1'b0);
      run_cycle(1'b1, 1'b1);
    end
    finish_test;
  end
endmodule
